//--- logic/lvd_ctrl.sv
/*
 Low-voltage detector control: APB register file, supply comparison, qualified
 interrupt request into a multi-function group, wake-up and event interrupt.
 Assumes supply_mv is a synchronous digital reading of the supply in millivolts
 and that the core pulses irq_ack for one cycle when it takes the group vector.
*/
`timescale 1ns/1ps
module lvd_ctrl import lvd_pkg::*; (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [11:0] supply_mv,
   input wire logic sleep_mode,
   input wire logic stack_full,
   input wire logic irq_ack,
   output logic detector_power_on,
   output logic reference_on,
   output logic [2:0] threshold_select,
   output logic mf_irq_req,
   output logic wake_req,
   output logic irq
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   lvd_state_t s_q;
   lvd_state_t s_d;
   logic settle_done;
   logic irq_done;
   logic setup;
   logic access;
   logic wr_ctrl;
   logic wr_irqc;
   logic rd_stat;
   logic below;
   logic irq_set;
   logic irq_rise;
   logic [2:0] events;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Settled status rises once the enable has stood for the settle time
   lvd_delay #(.CYC(SETTLE_CYC)) u_settle (
      .mclk(mclk),
      .rst_n(rst_n),
      .arm(s_q.en),
      .done(settle_done)
   );

   // Request raised only after the flag has stood for irq_delay
   lvd_delay #(.CYC(IRQ_CYC)) u_irq_dly (
      .mclk(mclk),
      .rst_n(rst_n),
      .arm(s_q.flag),
      .done(irq_done)
   );

   function automatic logic [2:0] bus_bits(input logic [31:0] w, input int lsb);
      bus_bits = w[lsb +: 3];
   endfunction : bus_bits

   always_comb begin
      setup = psel && !penable;
      access = psel && penable && s_q.pready;
      wr_ctrl = access && pwrite && paddr == LVD_CTRL_OFF;
      wr_irqc = access && pwrite && paddr == LVD_IRQC_OFF;
      rd_stat = access && !pwrite && paddr == LVD_STAT_OFF;
      // Unfiltered comparison, it may chatter near the trip level
      below = s_q.en && (supply_mv < threshold_mv(s_q.thr));
      irq_set = irq_done && !s_q.irq_done_prev;
   end

   always_comb begin
      s_d = s_q;
      events = 3'h0;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;

      case (s_q.bus)
         LVD_BUS_IDLE: begin
            if (setup) begin
               s_d.bus = LVD_BUS_ACCESS;
               s_d.pready = 1'b1;
               s_d.prdata = 32'h0;
               case (paddr)
                  LVD_CTRL_OFF: begin
                     // Bits 7, 6 and 3 stay zero
                     s_d.prdata[CTRL_THR_LSB +: 3] = s_q.thr;
                     s_d.prdata[CTRL_EN_BIT] = s_q.en;
                     s_d.prdata[CTRL_FLAG_BIT] = s_q.flag;
                  end
                  LVD_IRQC_OFF: begin
                     s_d.prdata[IRQC_FLAG_BIT] = s_q.irq_flag;
                     s_d.prdata[IRQC_LVE_BIT] = s_q.low_voltage_irq_enable;
                     s_d.prdata[IRQC_GRPE_BIT] = s_q.grpe;
                     s_d.prdata[IRQC_GIE_BIT] = s_q.gie;
                     s_d.prdata[IRQC_GRPF_BIT] = s_q.grpf;
                     s_d.prdata[IRQC_SETTLED_BIT] = settle_done;
                  end
                  LVD_STAT_OFF: begin
                     s_d.prdata[2:0] = s_q.status;
                  end
                  LVD_MASK_OFF: begin
                     s_d.prdata[2:0] = s_q.mask;
                  end
                  default: begin
                     s_d.pslverr = 1'b1;
                  end
               endcase
            end
         end
         LVD_BUS_ACCESS: begin
            s_d.bus = LVD_BUS_IDLE;
         end
         default: begin
            s_d.bus = LVD_BUS_IDLE;
         end
      endcase

      if (wr_ctrl) begin
         // The flag position of the write data is dropped
         s_d.thr = bus_bits(pwdata, CTRL_THR_LSB);
         s_d.en = pwdata[CTRL_EN_BIT];
      end
      if (access && pwrite && paddr == LVD_MASK_OFF) begin
         s_d.mask = pwdata[2:0];
      end

      s_d.flag = below;

      if (wr_irqc) begin
         // Writing 1 before sleep suppresses the later wake edge
         s_d.irq_flag = pwdata[IRQC_FLAG_BIT];
         s_d.low_voltage_irq_enable = pwdata[IRQC_LVE_BIT];
         s_d.grpe = pwdata[IRQC_GRPE_BIT];
         s_d.gie = pwdata[IRQC_GIE_BIT];
         s_d.grpf = pwdata[IRQC_GRPF_BIT];
      end
      if (irq_ack) begin
         // Source flag is left for software to clear
         s_d.gie = 1'b0;
         s_d.grpf = 1'b0;
      end
      s_d.irq_done_prev = irq_done;
      if (irq_set) begin
         s_d.irq_flag = 1'b1;
      end
      // Request enters the shared group flag
      if (irq_set && s_d.low_voltage_irq_enable) begin
         s_d.grpf = 1'b1;
      end

      irq_rise = s_d.irq_flag && !s_q.irq_flag;
      s_d.mf_req = s_d.gie && s_d.low_voltage_irq_enable && s_d.grpe && s_d.grpf && !stack_full;
      // Wake on any rising request flag, enables not consulted
      s_d.wake = irq_rise && sleep_mode;

      events[STAT_LOW_BIT] = below && !s_q.flag;
      events[STAT_IRQ_BIT] = irq_rise;
      events[STAT_WAKE_BIT] = s_d.wake;
      // Read clears, a new event in the same cycle survives
      s_d.status = (s_q.status & {3{!rd_stat}}) | events;
      s_d.irq = |(s_d.status & s_d.mask);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.thr <= THR_RST;
         s_q.en <= EN_RST;
         s_q.mask <= MASK_RST;
         s_q.bus <= LVD_BUS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   // Detector and its reference share the enable, also in power-down
   assign detector_power_on = s_q.en;
   assign reference_on = s_q.en;
   assign threshold_select = s_q.thr;
   assign mf_irq_req = s_q.mf_req;
   assign wake_req = s_q.wake;
   assign irq = s_q.irq;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_enable_powers;
      wr_ctrl && pwdata[CTRL_EN_BIT] |=> detector_power_on && reference_on ##1 detector_power_on;
   endproperty
   a_enable_powers: assert property (p_enable_powers) else $error("detector not powered after enable");

   property p_disable_off;
      wr_ctrl && !pwdata[CTRL_EN_BIT] |=> !detector_power_on && !reference_on;
   endproperty
   a_disable_off: assert property (p_disable_off) else $error("detector still powered after disable");

   property p_trip_level;
      s_q.en && !wr_ctrl && supply_mv < threshold_mv(s_q.thr) |=> s_q.flag;
   endproperty
   a_trip_level: assert property (p_trip_level) else $error("flag low while supply below level");

   property p_above_clear;
      s_q.en && !wr_ctrl && supply_mv >= threshold_mv(s_q.thr) |=> !s_q.flag;
   endproperty
   a_above_clear: assert property (p_above_clear) else $error("flag high while supply above level");

   property p_ctrl_zero_bits;
      setup && !pwrite && paddr == LVD_CTRL_OFF |=> pready && prdata[7:6] == 2'b00 && !prdata[3] && prdata[31:8] == 24'h0;
   endproperty
   a_ctrl_zero_bits: assert property (p_ctrl_zero_bits) else $error("unused control bits read nonzero");

   property p_irq_delay;
      $rose(irq_done) |-> $past(s_q.flag, IRQ_CYC);
   endproperty
   a_irq_delay: assert property (p_irq_delay) else $error("request set before delay elapsed");

   property p_group_route;
      irq_set && s_q.low_voltage_irq_enable && !irq_ack |=> s_q.grpf && s_q.irq_flag;
   endproperty
   a_group_route: assert property (p_group_route) else $error("group flag not set by request");

   property p_sleep_keeps;
      sleep_mode && s_q.en && !wr_ctrl |=> detector_power_on;
   endproperty
   a_sleep_keeps: assert property (p_sleep_keeps) else $error("detector dropped in power-down");

   property p_vector_gate;
      mf_irq_req |-> s_q.gie && s_q.low_voltage_irq_enable && s_q.grpe && s_q.grpf && !$past(stack_full);
   endproperty
   a_vector_gate: assert property (p_vector_gate) else $error("vector requested while gated");

   property p_service;
      irq_ack && !wr_irqc && s_q.irq_flag |=> !s_q.gie && s_q.irq_flag && (!s_q.grpf || $past(irq_set));
   endproperty
   a_service: assert property (p_service) else $error("service did not clear enables correctly");

   property p_wake;
      !s_q.irq_flag && irq_set && sleep_mode |=> wake_req ##1 !wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake pulse on request edge");

   property p_flag_write_ignored;
      wr_ctrl && pwdata[CTRL_FLAG_BIT] && !pwdata[CTRL_EN_BIT] |-> ##2 !s_q.flag;
   endproperty
   a_flag_write_ignored: assert property (p_flag_write_ignored) else $error("flag followed written data");

   property p_thr_write;
      wr_ctrl |=> threshold_select == $past(pwdata[2:0]);
   endproperty
   a_thr_write: assert property (p_thr_write) else $error("threshold select not taken from write");

   property p_off_no_flag;
      !s_q.en |=> !s_q.flag;
   endproperty
   a_off_no_flag: assert property (p_off_no_flag) else $error("flag set while detector off");

   property p_ref_with_detector;
      reference_on == detector_power_on;
   endproperty
   a_ref_with_detector: assert property (p_ref_with_detector) else $error("reference and detector differ");

   property p_ctrl_flag_read;
      setup && !pwrite && paddr == LVD_CTRL_OFF |=> prdata[CTRL_FLAG_BIT] == $past(s_q.flag);
   endproperty
   a_ctrl_flag_read: assert property (p_ctrl_flag_read) else $error("flag bit read wrong");

   property p_flag_unfiltered;
      s_q.en && !wr_ctrl && ((supply_mv < threshold_mv(s_q.thr)) != s_q.flag) |=> $changed(s_q.flag);
   endproperty
   a_flag_unfiltered: assert property (p_flag_unfiltered) else $error("flag missed a crossing");

   property p_no_early_request;
      $rose(s_q.flag) |=> (!irq_done) [*8];
   endproperty
   a_no_early_request: assert property (p_no_early_request) else $error("request qualified too early");

   property p_awake_no_wake;
      !sleep_mode |=> !wake_req;
   endproperty
   a_awake_no_wake: assert property (p_awake_no_wake) else $error("wake pulse while awake");

   property p_wake_any_enable;
      sleep_mode && irq_rise |=> wake_req;
   endproperty
   a_wake_any_enable: assert property (p_wake_any_enable) else $error("flag rise gave no wake");

   property p_ack_drops_request;
      irq_ack && !irq_set && !wr_irqc |=> !s_q.grpf && !mf_irq_req;
   endproperty
   a_ack_drops_request: assert property (p_ack_drops_request) else $error("request kept after service");

   property p_stack_full_blocks;
      stack_full |=> !mf_irq_req;
   endproperty
   a_stack_full_blocks: assert property (p_stack_full_blocks) else $error("vector requested with full stack");

   property p_sleep_off_stays;
      sleep_mode && !s_q.en && !wr_ctrl |=> !detector_power_on;
   endproperty
   a_sleep_off_stays: assert property (p_sleep_off_stays) else $error("detector on in power-down");
endmodule : lvd_ctrl

//--- logic/lvd_delay.sv
/*
 Qualifying delay: done rises after arm has been high for CYC cycles and falls
 as soon as arm falls.
 Assumes arm is synchronous to mclk.
*/
`timescale 1ns/1ps
module lvd_delay import lvd_pkg::*; #(
   parameter int CYC = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic arm,
   output logic done
);
   lvd_dly_state_t s_q;
   lvd_dly_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (!arm) begin
         s_d.cnt = 13'h0;
         s_d.done = 1'b0;
      end else if (s_q.cnt >= 13'(CYC - 1)) begin
         s_d.done = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 13'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
endmodule : lvd_delay

//--- logic/lvd_pkg.sv
/*
 Constants, field positions, reset values, timing counts and state types of the
 low-voltage detector control block.
 Assumes a 100 MHz mclk and a 32-bit APB master with 8-bit addresses.
*/
package lvd_pkg;
   // Register byte addresses
   localparam logic [7:0] LVD_CTRL_OFF = 8'h00;
   localparam logic [7:0] LVD_IRQC_OFF = 8'h04;
   localparam logic [7:0] LVD_STAT_OFF = 8'h08;
   localparam logic [7:0] LVD_MASK_OFF = 8'h0c;

   // low_voltage_control_reg fields
   localparam int CTRL_THR_LSB = 0;
   localparam int CTRL_EN_BIT = 4;
   localparam int CTRL_FLAG_BIT = 5;
   // Interrupt control register fields
   localparam int IRQC_FLAG_BIT = 0;
   localparam int IRQC_LVE_BIT = 1;
   localparam int IRQC_GRPE_BIT = 2;
   localparam int IRQC_GIE_BIT = 3;
   localparam int IRQC_GRPF_BIT = 4;
   localparam int IRQC_SETTLED_BIT = 5;
   // Event status and mask fields
   localparam int STAT_LOW_BIT = 0;
   localparam int STAT_IRQ_BIT = 1;
   localparam int STAT_WAKE_BIT = 2;

   // Reset values
   localparam logic [2:0] THR_RST = 3'h0;
   localparam logic EN_RST = 1'b0;
   localparam logic [2:0] MASK_RST = 3'h0;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_NS = 2000;
   localparam int IRQ_DELAY_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IRQ_CYC = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Trip level in millivolts for a threshold code
   function automatic logic [11:0] threshold_mv(input logic [2:0] sel);
      case (sel)
         3'h0: threshold_mv = 12'd2000;
         3'h1: threshold_mv = 12'd2200;
         3'h2: threshold_mv = 12'd2400;
         3'h3: threshold_mv = 12'd2700;
         3'h4: threshold_mv = 12'd3000;
         3'h5: threshold_mv = 12'd3300;
         3'h6: threshold_mv = 12'd3600;
         default: threshold_mv = 12'd4000;
      endcase
   endfunction : threshold_mv

   typedef enum logic [1:0] {
      LVD_BUS_IDLE,
      LVD_BUS_ACCESS
   } lvd_bus_t;

   typedef struct packed {
      logic [2:0] thr;
      logic en;
      logic flag;
      logic irq_flag;
      logic low_voltage_irq_enable;
      logic grpe;
      logic gie;
      logic grpf;
      logic irq_done_prev;
      logic [2:0] status;
      logic [2:0] mask;
      lvd_bus_t bus;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic mf_req;
      logic wake;
   } lvd_state_t;

   typedef struct packed {
      logic [12:0] cnt;
      logic done;
   } lvd_dly_state_t;
endpackage : lvd_pkg

//--- tb/lvd_ctrl_tb_top.sv
/*
 Self-checking bench for the low-voltage detector control block.
 Assumes the register map, timing counts and field layout of the design package.
*/
`timescale 1ns/1ps
module lvd_ctrl_tb_top import lvd_pkg::*; ;
   logic mclk, rstn, psel, penable, pwrite, sleep_mode, stack_full, irq_ack;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er, detector_power_on, reference_on, mf_irq_req, wake_req, irq;
   logic [11:0] supply_mv;
   logic [2:0] threshold_select;
   logic [11:0] thr_tab [8] = '{12'd2000, 12'd2200, 12'd2400, 12'd2700, 12'd3000, 12'd3300, 12'd3600, 12'd4000};
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;

   lvd_ctrl dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_mv(supply_mv), .sleep_mode(sleep_mode), .stack_full(stack_full), .irq_ack(irq_ack),
      .detector_power_on(detector_power_on), .reference_on(reference_on),
      .threshold_select(threshold_select), .mf_irq_req(mf_irq_req), .wake_req(wake_req), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic final_report;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         final_report();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   // One APB transfer; entered just after a rising edge, leaves one idle edge behind
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic waitfor(input logic wake, input int lim, output int n);
      n = 0;
      while ((wake ? wake_req : mf_irq_req) !== 1'b1 && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask : waitfor

   task automatic t_ctrl;
      chk("power_rst", detector_power_on, 1'b0);
      apb(1'b0, LVD_CTRL_OFF, 32'h0);
      chk("ctrl_rst", rd, 32'h0);
      apb(1'b0, LVD_IRQC_OFF, 32'h0);
      chk("irqc_rst", rd, 32'h0);
      apb(1'b0, LVD_MASK_OFF, 32'h0);
      chk("mask_rst", rd, 32'h0);
      apb(1'b1, LVD_CTRL_OFF, 32'hff);
      apb(1'b0, LVD_IRQC_OFF, 32'h0);
      chk("settle_early", rd[IRQC_SETTLED_BIT], 1'b0);
      tick(SETTLE_CYC);
      apb(1'b0, LVD_IRQC_OFF, 32'h0);
      chk("settle_done", rd[IRQC_SETTLED_BIT], 1'b1);
      apb(1'b0, LVD_CTRL_OFF, 32'h0);
      chk("ctrl_loose_bits", rd, 32'h17);
      chk("power_on", detector_power_on, 1'b1);
      chk("ref_on", reference_on, 1'b1);
      chk("thr_out", threshold_select, 3'h7);
   endtask : t_ctrl

   task automatic t_thr;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, LVD_CTRL_OFF, 32'h10 | i);
         supply_mv <= thr_tab[i] - 12'd1;
         tick(3);
         apb(1'b0, LVD_CTRL_OFF, 32'h0);
         chk("ctrl_below", rd, 32'h30 | i);
         chk("thr_sel", threshold_select, i[2:0]);
         supply_mv <= thr_tab[i] + 12'd1;
         tick(3);
         apb(1'b0, LVD_CTRL_OFF, 32'h0);
         chk("ctrl_above", rd, 32'h10 | i);
      end
   endtask : t_thr

   task automatic t_irq;
      int n;
      supply_mv <= 12'd2500;
      apb(1'b1, LVD_CTRL_OFF, 32'h10);
      apb(1'b1, LVD_IRQC_OFF, 32'h0);
      apb(1'b1, LVD_IRQC_OFF, 32'h0e);
      supply_mv <= 12'd1500;
      waitfor(1'b0, 300, n);
      chk("irq_delay", (n >= IRQ_CYC && n <= IRQ_CYC + 6), 1'b1);
      stack_full <= 1'b1;
      tick(3);
      chk("req_stack_full", mf_irq_req, 1'b0);
      stack_full <= 1'b0;
      tick(3);
      chk("req_back", mf_irq_req, 1'b1);
      irq_ack <= 1'b1;
      tick(1);
      irq_ack <= 1'b0;
      tick(3);
      chk("req_after_ack", mf_irq_req, 1'b0);
      apb(1'b0, LVD_IRQC_OFF, 32'h0);
      chk("irqc_after_ack", rd & 32'h1f, 32'h07);
   endtask : t_irq

   task automatic t_wake;
      int n;
      supply_mv <= 12'd2500;
      sleep_mode <= 1'b1;
      tick(3);
      supply_mv <= 12'd1500;
      waitfor(1'b1, 150, n);
      chk("no_wake_preset", n, 150);
      sleep_mode <= 1'b0;
      supply_mv <= 12'd2500;
      apb(1'b1, LVD_IRQC_OFF, 32'h0);
      sleep_mode <= 1'b1;
      supply_mv <= 12'd1500;
      waitfor(1'b1, 150, n);
      chk("wake_seen", n < 150, 1'b1);
      sleep_mode <= 1'b0;
   endtask : t_wake

   task automatic t_stat;
      apb(1'b1, LVD_MASK_OFF, 32'h1);
      apb(1'b0, LVD_STAT_OFF, 32'h0);
      supply_mv <= 12'd2500;
      tick(3);
      chk("irq_idle", irq, 1'b0);
      supply_mv <= 12'd1500;
      tick(3);
      chk("irq_raised", irq, 1'b1);
      apb(1'b0, LVD_STAT_OFF, 32'h0);
      chk("stat_val", rd, 32'h1);
      tick(2);
      chk("irq_cleared", irq, 1'b0);
      apb(1'b1, LVD_MASK_OFF, 32'h0);
      supply_mv <= 12'd2500;
      tick(3);
      supply_mv <= 12'd1500;
      tick(3);
      chk("irq_masked", irq, 1'b0);
      apb(1'b0, LVD_STAT_OFF, 32'h0);
      chk("stat_masked", rd, 32'h1);
   endtask : t_stat

   task automatic t_off;
      apb(1'b1, LVD_CTRL_OFF, 32'h23);
      tick(2);
      apb(1'b0, LVD_CTRL_OFF, 32'h0);
      chk("ctrl_off", rd, 32'h03);
      chk("power_off", detector_power_on, 1'b0);
      chk("ref_off", reference_on, 1'b0);
      sleep_mode <= 1'b1;
      tick(3);
      chk("sleep_off", detector_power_on, 1'b0);
      sleep_mode <= 1'b0;
   endtask : t_off

   task automatic t_unmap;
      apb(1'b1, 8'h10, 32'hff);
      chk("unmap_werr", er, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmap_rerr", er, 1'b1);
      chk("unmap_rd", rd, 32'h0);
      apb(1'b0, LVD_CTRL_OFF, 32'h0);
      chk("ctrl_kept", rd, 32'h03);
      chk("ctrl_err", er, 1'b0);
   endtask : t_unmap

   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      supply_mv = 12'd4095;
      sleep_mode = 1'b0;
      stack_full = 1'b0;
      irq_ack = 1'b0;
      tick(8);
      rstn <= 1'b1;
      tick(3);
      t_ctrl();
      t_thr();
      t_irq();
      t_wake();
      t_stat();
      t_off();
      t_unmap();
      final_report();
   end
endmodule : lvd_ctrl_tb_top
